// ==== design/rss_pkg.sv ====
// Shared constants and types for the rotate/subtract/swap/sleep execution block.
// Assumes one 20 MHz core clock and a synchronous active-high reset.
package rss_pkg;

  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int FADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int BUS_ADDR_W = 8;
  localparam int CLK_MHZ = 20;

  // Register port map; file array occupies 8'h00..8'h7f
  localparam logic [BUS_ADDR_W-1:0] ADDR_WORKING = 8'h80;
  localparam logic [BUS_ADDR_W-1:0] ADDR_STATUS = 8'h81;
  localparam logic [BUS_ADDR_W-1:0] ADDR_CORE_STATE = 8'h82;
  localparam int ADDR_FILE_SEL_BIT = 7;

  // Destination select
  localparam logic DEST_WORKING = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Status field layout (bit positions of rss_status_t)
  localparam int STATUS_W = 5;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h18;
  localparam logic [STATUS_W-1:0] STATUS_SW_MASK = 5'h07;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    OP_ROTATE_RIGHT_THROUGH_CARRY,
    OP_LITERAL_MINUS_WORKING,
    OP_FILE_MINUS_WORKING,
    OP_FILE_MINUS_WORKING_WITH_BORROW,
    OP_NIBBLE_SWAP,
    OP_SLEEP
  } rss_op_t;

  typedef struct packed {
    rss_op_t op;
    logic [FADDR_W-1:0] file_addr;
    logic dest;
    logic [DATA_W-1:0] literal;
  } rss_instr_t;

  typedef struct packed {
    logic time_out_flag_n;
    logic power_down_flag_n;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } rss_status_t;

  typedef enum logic {
    CORE_RUN,
    CORE_ASLEEP
  } rss_core_state_t;

endpackage : rss_pkg

// ==== design/rss_alu.sv ====
// Combinational datapath: rotate right through carry, three subtractions, nibble swap.
// Assumes operands are stable for the whole cycle in which the core latches results.
`timescale 1ns/1ps
`default_nettype none
module rss_alu (
  input wire rss_pkg::rss_op_t op_i,
  input wire logic [rss_pkg::DATA_W-1:0] file_i,
  input wire logic [rss_pkg::DATA_W-1:0] work_i,
  input wire logic [rss_pkg::DATA_W-1:0] literal_i,
  input wire logic carry_i,
  output logic [rss_pkg::DATA_W-1:0] result_o,
  output logic carry_o,
  output logic digit_carry_o,
  output logic zero_o
);

  localparam int DW = rss_pkg::DATA_W;
  localparam int NW = rss_pkg::NIB_W;

  wire logic is_literal_op;
  wire logic is_borrow_op;
  wire logic carry_in;
  wire logic [DW-1:0] minuend;
  wire logic [DW:0] diff_full;
  wire logic [NW:0] diff_low;

  ////////////////////////////////////////////////////////////////////////////
  // Subtraction as minuend + ~W + carry_in; carry out is not-borrow
  assign is_literal_op = (op_i == rss_pkg::OP_LITERAL_MINUS_WORKING);
  assign is_borrow_op = (op_i == rss_pkg::OP_FILE_MINUS_WORKING_WITH_BORROW);
  assign minuend = is_literal_op ? literal_i : file_i;
  assign carry_in = is_borrow_op ? carry_i : 1'b1;
  assign diff_full = {1'b0, minuend} + {1'b0, ~work_i} + {{DW{1'b0}}, carry_in};
  assign diff_low = {1'b0, minuend[NW-1:0]} + {1'b0, ~work_i[NW-1:0]}
                    + {{NW{1'b0}}, carry_in};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    result_o = file_i;
    carry_o = carry_i;
    case (op_i)
      rss_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        result_o = {carry_i, file_i[DW-1:1]};
        carry_o = file_i[0];
      end
      rss_pkg::OP_LITERAL_MINUS_WORKING,
      rss_pkg::OP_FILE_MINUS_WORKING,
      rss_pkg::OP_FILE_MINUS_WORKING_WITH_BORROW: begin
        result_o = diff_full[DW-1:0];
        carry_o = diff_full[DW];
      end
      rss_pkg::OP_NIBBLE_SWAP: begin
        result_o = {file_i[NW-1:0], file_i[DW-1:NW]};
      end
      default: begin
        result_o = file_i;
        carry_o = carry_i;
      end
    endcase
  end

  assign digit_carry_o = diff_low[NW];
  assign zero_o = (result_o == rss_pkg::ZERO_BYTE);

endmodule : rss_alu
`default_nettype wire

// ==== design/rss_core.sv ====
// Execution core for rotate, subtract, swap and sleep, with working register,
// status flags and a 128-byte file array reachable over a plain register port.
// Assumes instructions arrive from same-clock logic; wake_i is an asynchronous pin.
//
// Functional notes
// - Rotate right shifts the file register down one bit, carry enters bit 7, bit 0 becomes carry.
// - Destination 0 sends the result to the working register and 1 back to the file register.
// - Literal minus working computes k - W and puts the result in W, updating C, DC and Z.
// - File minus working computes f - W into the chosen destination, updating C, DC and Z.
// - Subtract with borrow computes f - W - not carry into the destination, updating C, DC and Z.
// - Nibble swap exchanges the two halves of f into the destination and touches no flag.
// - Sleep clears the active-low power-down flag.
// - Sleep sets the active-low time-out flag.
// - Sleep clears the watchdog counter and its prescaler.
// - After sleep the core enters its low-power state and asks for the oscillator to stop.
`timescale 1ns/1ps
`default_nettype none
module rss_core #(
  parameter int FILE_DEPTH = rss_pkg::FILE_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire rss_pkg::rss_instr_t instr_i,
  output logic instr_ready_o,
  input wire logic wake_i,
  input wire logic [rss_pkg::BUS_ADDR_W-1:0] reg_addr_i,
  input wire logic [rss_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [rss_pkg::DATA_W-1:0] reg_rdata_o,
  output logic [rss_pkg::DATA_W-1:0] working_o,
  output rss_pkg::rss_status_t status_o,
  output logic [rss_pkg::DATA_W-1:0] result_o,
  output logic exec_done_o,
  output logic watchdog_clear_o,
  output logic sleep_o,
  output logic osc_stop_req_o
);

  localparam int DW = rss_pkg::DATA_W;
  localparam int AW = rss_pkg::FADDR_W;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [DW-1:0] file_mem_q [FILE_DEPTH];
  logic [DW-1:0] working_q;
  logic [DW-1:0] working_d;
  rss_pkg::rss_status_t status_q;
  rss_pkg::rss_status_t status_d;
  rss_pkg::rss_core_state_t state_q;
  rss_pkg::rss_core_state_t state_d;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;
  logic [DW-1:0] result_q;
  logic exec_done_q;
  logic watchdog_clear_q;
  logic wake_meta_q;
  logic wake_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  wire logic exec;
  wire logic is_rotate;
  wire logic is_lit_sub;
  wire logic is_file_sub;
  wire logic is_borrow_sub;
  wire logic is_swap;
  wire logic is_sleep;
  wire logic is_sub;
  wire logic has_dest;
  wire logic dest_is_file;
  wire logic dest_is_working;
  wire logic [DW-1:0] file_operand;
  wire logic [DW-1:0] alu_result;
  wire logic alu_carry;
  wire logic alu_digit_carry;
  wire logic alu_zero;
  wire logic take_sleep;
  wire logic upd_carry;
  wire logic upd_arith_flags;
  wire logic upd_result;
  wire logic asleep;
  wire logic wake_seen;

  // Instructions are refused while asleep; the sequencer must hold them off
  assign asleep = (state_q == rss_pkg::CORE_ASLEEP);
  assign instr_ready_o = (state_q == rss_pkg::CORE_RUN);
  assign exec = instr_valid_i & instr_ready_o;
  assign is_rotate = (instr_i.op == rss_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY);
  assign is_lit_sub = (instr_i.op == rss_pkg::OP_LITERAL_MINUS_WORKING);
  assign is_file_sub = (instr_i.op == rss_pkg::OP_FILE_MINUS_WORKING);
  assign is_borrow_sub = (instr_i.op == rss_pkg::OP_FILE_MINUS_WORKING_WITH_BORROW);
  assign is_swap = (instr_i.op == rss_pkg::OP_NIBBLE_SWAP);
  assign is_sleep = (instr_i.op == rss_pkg::OP_SLEEP);
  assign is_sub = is_lit_sub | is_file_sub | is_borrow_sub;
  assign has_dest = is_rotate | is_file_sub | is_borrow_sub | is_swap;
  assign dest_is_file = exec & has_dest & (instr_i.dest == rss_pkg::DEST_FILE);
  assign dest_is_working = exec & ((has_dest & (instr_i.dest == rss_pkg::DEST_WORKING))
                           | is_lit_sub);
  assign file_operand = file_mem_q[instr_i.file_addr];

  ////////////////////////////////////////////////////////////////////////////
  // Flag and result update enables
  assign take_sleep = exec & is_sleep;
  assign upd_carry = exec & (is_rotate | is_sub);
  assign upd_arith_flags = exec & is_sub;
  // Sleep keeps the last ALU value on the result port for software to inspect
  assign upd_result = exec & ~is_sleep;
  // A wake pulse shorter than one clock may be missed by the synchroniser
  assign wake_seen = wake_sync_q;

  rss_alu u_alu (
    .op_i(instr_i.op),
    .file_i(file_operand),
    .work_i(working_q),
    .literal_i(instr_i.literal),
    .carry_i(status_q.carry),
    .result_o(alu_result),
    .carry_o(alu_carry),
    .digit_carry_o(alu_digit_carry),
    .zero_o(alu_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  wire logic bus_is_file;
  wire logic [AW-1:0] bus_file_addr;
  wire logic bus_wr_file;
  wire logic bus_wr_working;
  wire logic bus_wr_status;
  wire logic [DW-1:0] status_byte;
  wire logic [DW-1:0] state_byte;
  wire logic [rss_pkg::STATUS_W-1:0] status_sw_bits;
  wire logic bus_at_working;
  wire logic bus_at_status;
  wire logic bus_at_state;
  wire logic [DW-1:0] bus_file_data;

  assign bus_is_file = ~reg_addr_i[rss_pkg::ADDR_FILE_SEL_BIT];
  assign bus_file_addr = reg_addr_i[AW-1:0];
  assign bus_at_working = (reg_addr_i == rss_pkg::ADDR_WORKING);
  assign bus_at_status = (reg_addr_i == rss_pkg::ADDR_STATUS);
  assign bus_at_state = (reg_addr_i == rss_pkg::ADDR_CORE_STATE);
  assign bus_file_data = file_mem_q[bus_file_addr];
  // Instruction writes win over a register-port write to the same location
  assign bus_wr_file = reg_wr_i & bus_is_file
                       & ~(dest_is_file & (instr_i.file_addr == bus_file_addr));
  assign bus_wr_working = reg_wr_i & bus_at_working & ~dest_is_working;
  assign bus_wr_status = reg_wr_i & bus_at_status;
  assign status_byte = {{(DW - rss_pkg::STATUS_W){1'b0}}, status_q};
  assign state_byte = {{(DW - 1){1'b0}}, asleep};
  // Power flags are read-only from the port; only C, DC and Z are writable
  assign status_sw_bits = (reg_wdata_i[rss_pkg::STATUS_W-1:0] & rss_pkg::STATUS_SW_MASK)
                          | (status_q & ~rss_pkg::STATUS_SW_MASK);

  // Read data are zero outside a read so a stale byte never looks like an answer
  always_comb begin
    rdata_d = rss_pkg::ZERO_BYTE;
    if (reg_rd_i) begin
      if (bus_is_file) begin
        rdata_d = bus_file_data;
      end else if (bus_at_working) begin
        rdata_d = working_q;
      end else if (bus_at_status) begin
        rdata_d = status_byte;
      end else if (bus_at_state) begin
        rdata_d = state_byte;
      end else begin
        rdata_d = rss_pkg::ZERO_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next working register and status flags
  always_comb begin
    working_d = working_q;
    if (dest_is_working) begin
      working_d = alu_result;
    end else if (bus_wr_working) begin
      working_d = reg_wdata_i;
    end
  end

  always_comb begin
    status_d = status_q;
    // Port writes reach only C, DC and Z; the power flags change by sleep alone
    if (bus_wr_status) begin
      status_d = rss_pkg::rss_status_t'(status_sw_bits);
    end
    // Hardware flag updates override a same-cycle port write
    if (upd_carry) begin
      status_d.carry = alu_carry;
    end
    if (upd_arith_flags) begin
      status_d.digit_carry_flag = alu_digit_carry;
      status_d.zero = alu_zero;
    end
    if (take_sleep) begin
      status_d.power_down_flag_n = 1'b0;
      status_d.time_out_flag_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power state; wake comes only from the synchronised pin
  always_comb begin
    state_d = state_q;
    case (state_q)
      rss_pkg::CORE_RUN: begin
        if (take_sleep) begin
          state_d = rss_pkg::CORE_ASLEEP;
        end
      end
      rss_pkg::CORE_ASLEEP: begin
        if (wake_seen) begin
          state_d = rss_pkg::CORE_RUN;
        end
      end
      default: begin
        // An unknown state falls back to running so the core cannot lock up asleep
        state_d = rss_pkg::CORE_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_i;
      wake_sync_q <= wake_meta_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      working_q <= rss_pkg::ZERO_BYTE;
      status_q <= rss_pkg::rss_status_t'(rss_pkg::STATUS_RESET);
      state_q <= rss_pkg::CORE_RUN;
      rdata_q <= rss_pkg::ZERO_BYTE;
    end else begin
      working_q <= working_d;
      status_q <= status_d;
      state_q <= state_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values for the result, the pulses and the file array
  wire logic [DW-1:0] result_d;
  wire logic file_we;
  wire logic [AW-1:0] file_waddr;
  wire logic [DW-1:0] file_wdata;

  assign result_d = upd_result ? alu_result : result_q;
  assign file_we = dest_is_file | bus_wr_file;
  assign file_waddr = dest_is_file ? instr_i.file_addr : bus_file_addr;
  assign file_wdata = dest_is_file ? alu_result : reg_wdata_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      result_q <= rss_pkg::ZERO_BYTE;
      exec_done_q <= 1'b0;
      watchdog_clear_q <= 1'b0;
    end else begin
      result_q <= result_d;
      exec_done_q <= exec;
      watchdog_clear_q <= take_sleep;
    end
  end

  // File array holds data only, so it carries no reset
  always_ff @(posedge sys_clk_i) begin
    if (file_we) begin
      file_mem_q[file_waddr] <= file_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_o = rdata_q;
  assign working_o = working_q;
  assign status_o = status_q;
  assign result_o = result_q;
  assign exec_done_o = exec_done_q;
  assign watchdog_clear_o = watchdog_clear_q;
  assign sleep_o = asleep;
  assign osc_stop_req_o = asleep;

endmodule : rss_core
`default_nettype wire

// ==== bench/rss_core_props.sv ====
// Port checker for the rotate/subtract/swap/sleep core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rss_core_props (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire rss_pkg::rss_instr_t instr_i,
  input wire logic instr_ready_o,
  input wire logic reg_wr_i,
  input wire logic [7:0] working_o,
  input wire rss_pkg::rss_status_t status_o,
  input wire logic [7:0] result_o,
  input wire logic exec_done_o,
  input wire logic watchdog_clear_o,
  input wire logic sleep_o,
  input wire logic osc_stop_req_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Port writes to status may land beside rotate or swap, so those are excluded
  wire tk = instr_valid_i && instr_ready_o;
  wire rot = tk && instr_i.op == rss_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY && !reg_wr_i;
  wire lit = tk && instr_i.op == rss_pkg::OP_LITERAL_MINUS_WORKING;
  wire fsub = tk && (instr_i.op == rss_pkg::OP_FILE_MINUS_WORKING
    || instr_i.op == rss_pkg::OP_FILE_MINUS_WORKING_WITH_BORROW);
  wire swp = tk && instr_i.op == rss_pkg::OP_NIBBLE_SWAP && !reg_wr_i;
  wire slp = tk && instr_i.op == rss_pkg::OP_SLEEP;
  wire [7:0] ldif = instr_i.literal - working_o;
  wire lc = working_o <= instr_i.literal;
  wire ldc = working_o[3:0] <= instr_i.literal[3:0];
  wire cy = status_o.carry;
  wire [3:0] st_hi = status_o[4:1];
  ////////////////////////////////////////////////////////////////////////////
  a_rotate_carry: assert property (rot |=> result_o[7] == $past(cy)
    && st_hi == $past(st_hi)) else $error("rotate flags wrong");
  a_dest_working: assert property (tk && instr_i.op != rss_pkg::OP_SLEEP && !instr_i.dest
    |=> working_o == result_o) else $error("result not in working");
  a_dest_file: assert property ((rot || fsub || swp) && instr_i.dest && !reg_wr_i
    |=> $stable(working_o)) else $error("working changed on file dest");
  a_literal_sub: assert property (lit |=> result_o == $past(ldif)
    && working_o == result_o) else $error("literal subtract wrong");
  a_literal_flags: assert property (lit |=> cy == $past(lc)
    && status_o.digit_carry_flag == $past(ldc)) else $error("subtract carries wrong");
  a_sub_zero: assert property (lit || fsub |=> status_o.zero == (result_o == 8'h00))
    else $error("zero flag wrong");
  a_swap_flags: assert property (swp |=> $stable(status_o))
    else $error("swap touched flags");
  a_sleep_flags: assert property (slp |=> !status_o.power_down_flag_n
    && status_o.time_out_flag_n) else $error("sleep flags wrong");
  a_sleep_state: assert property (slp |=> watchdog_clear_o && sleep_o
    && osc_stop_req_o && !instr_ready_o) else $error("sleep entry wrong");
  a_asleep_idle: assert property (sleep_o |-> !instr_ready_o ##1 !watchdog_clear_o)
    else $error("asleep core accepts work");
endmodule : rss_core_props
`default_nettype wire

// ==== bench/tb_top.sv ====
// Directed testbench for the rotate/subtract/swap/sleep core.
// Assumes the register map of the package; file address 8'h05 is used.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam rss_pkg::rss_op_t ROT = rss_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY;
  localparam rss_pkg::rss_op_t LIT = rss_pkg::OP_LITERAL_MINUS_WORKING;
  localparam rss_pkg::rss_op_t FMW = rss_pkg::OP_FILE_MINUS_WORKING;
  localparam rss_pkg::rss_op_t FMB = rss_pkg::OP_FILE_MINUS_WORKING_WITH_BORROW;
  localparam rss_pkg::rss_op_t SWP = rss_pkg::OP_NIBBLE_SWAP;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  rss_pkg::rss_instr_t instr_i = '0;
  logic wake_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  wire [7:0] reg_rdata_o, working_o, result_o;
  rss_pkg::rss_status_t status_o;
  wire instr_ready_o, exec_done_o, watchdog_clear_o, sleep_o, osc_stop_req_o;
  int errors = 0;
  int n_checks = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  rss_core uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o), .wake_i(wake_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .working_o(working_o),
    .status_o(status_o), .result_o(result_o), .exec_done_o(exec_done_o),
    .watchdog_clear_o(watchdog_clear_o), .sleep_o(sleep_o), .osc_stop_req_o(osc_stop_req_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask : rd
  task automatic issue(input rss_pkg::rss_op_t op, input logic d, input logic [7:0] k);
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= '{op, 7'h05, d, k};
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask : issue
  task automatic ex(input rss_pkg::rss_op_t op, input logic d, input logic [7:0] k);
    issue(op, d, k);
    chk({7'h00, exec_done_o}, 8'h01);
  endtask : ex
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(8'h81, 8'h18);
    rd(8'h80, 8'h00);
    rd(8'h82, 8'h00);
    wr(8'hc0, 8'h55);
    rd(8'hc0, 8'h00);
    wr(8'h81, 8'hff);
    rd(8'h81, 8'h1f);
    $display("test regs done");
  endtask : t_regs
  task automatic t_rotate();
    wr(8'h05, 8'h81);
    wr(8'h81, 8'h01);
    ex(ROT, 1'b1, 8'h00);
    rd(8'h05, 8'hc0);
    rd(8'h81, 8'h19);
    ex(ROT, 1'b0, 8'h00);
    rd(8'h80, 8'he0);
    rd(8'h05, 8'hc0);
    rd(8'h81, 8'h18);
    $display("test rotate done");
  endtask : t_rotate
  task automatic t_literal();
    logic [7:0] wv[3] = '{8'h05, 8'h04, 8'h01};
    logic [7:0] kv[3] = '{8'h05, 8'h03, 8'h10};
    logic [7:0] r;
    for (int i = 0; i < 3; i++) begin
      r = kv[i] - wv[i];
      wr(8'h80, wv[i]);
      ex(LIT, 1'b1, kv[i]);
      chk(working_o, r);
      rd(8'h81, {5'h03, r == 8'h00, wv[i][3:0] <= kv[i][3:0], wv[i] <= kv[i]});
    end
    $display("test literal done");
  endtask : t_literal
  task automatic t_file_sub();
    wr(8'h05, 8'h20);
    wr(8'h80, 8'h21);
    ex(FMW, 1'b1, 8'h00);
    chk(result_o, 8'hff);
    rd(8'h05, 8'hff);
    rd(8'h80, 8'h21);
    rd(8'h81, 8'h18);
    ex(FMW, 1'b0, 8'h00);
    rd(8'h80, 8'hde);
    rd(8'h81, 8'h1b);
    wr(8'h81, 8'h00);
    wr(8'h05, 8'h10);
    wr(8'h80, 8'h0f);
    ex(FMB, 1'b1, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h81, 8'h1d);
    wr(8'h05, 8'h10);
    ex(FMB, 1'b0, 8'h00);
    rd(8'h80, 8'h01);
    rd(8'h81, 8'h19);
    $display("test file subtract done");
  endtask : t_file_sub
  task automatic t_swap();
    wr(8'h81, 8'h07);
    wr(8'h05, 8'ha5);
    ex(SWP, 1'b0, 8'h00);
    rd(8'h80, 8'h5a);
    rd(8'h81, 8'h1f);
    ex(SWP, 1'b1, 8'h00);
    rd(8'h05, 8'h5a);
    $display("test swap done");
  endtask : t_swap
  task automatic t_sleep();
    ex(rss_pkg::OP_SLEEP, 1'b0, 8'h00);
    chk({4'h0, watchdog_clear_o, sleep_o, osc_stop_req_o, instr_ready_o}, 8'h0e);
    rd(8'h81, 8'h17);
    rd(8'h82, 8'h01);
    issue(SWP, 1'b0, 8'h00);
    chk({7'h00, exec_done_o}, 8'h00);
    rd(8'h80, 8'h5a);
    @(posedge sys_clk_i);
    wake_i <= 1'b1;
    @(posedge sys_clk_i);
    wake_i <= 1'b0;
    for (int i = 0; i < 10 && instr_ready_o !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    #1;
    chk({5'h00, sleep_o, osc_stop_req_o, instr_ready_o}, 8'h01);
    $display("test sleep done");
  endtask : t_sleep
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Tests need about 120 cycles; the 3000-cycle limit leaves wide margin
  initial begin
    #(3000 * 50);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_rotate();
    t_literal();
    t_file_sub();
    t_swap();
    t_sleep();
    give_verdict();
  end
endmodule : tb_top
bind rss_core rss_core_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
  .reg_wr_i(reg_wr_i), .working_o(working_o), .status_o(status_o), .result_o(result_o),
  .exec_done_o(exec_done_o), .watchdog_clear_o(watchdog_clear_o), .sleep_o(sleep_o),
  .osc_stop_req_o(osc_stop_req_o));
`default_nettype wire
